/* logic/ccee_channel_events.sv */
// CAN channel error/event and interrupt-source logic, with APB registers.
// Assumes the protocol engine gives one-cycle event strobes and bit ticks.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ccee_regs.svh"

// Notes on behaviour
// [RULE_01] Warning flag when receive or transmit error counter exceeds 95.
// [RULE_02] Passive flag when either counter exceeds 127; enable gates irq.
// [RULE_03] Bus-off-start flag when transmit counter exceeds 255.
// [RULE_04] Recovery flag after 128 runs of 11 recessive bits.
// [RULE_05] Overload flag on overload condition, receiving or transmitting.
// [RULE_06] Bus-lock flag on 32 dominant bits in communication mode.
// [RULE_07] Arbitration-lost flag each time arbitration is lost.
// [RULE_08] Wakeup request on falling edge of the receive line.
// [RULE_09] Each event reaches the interrupt only through its own enable.
// [RULE_10] Request holds until software clears the flag to zero.
// [RULE_11] Bus-error event when any of seven detection flags sets.
// [RULE_12] Bit-zero and bit-one errors from driven versus sampled level.
// [RULE_13] Receive FIFO threshold: eighths one to seven, or full.
// [RULE_14] Software avoids odd eighths when receive depth code is 001.
// [RULE_15] Transmit/receive FIFO has the same eight thresholds and limit.
// [RULE_16] Channel reset before recovery completes suppresses recovery flag.
// [RULE_17] Forced recovery leaves bus off without recovery flag.
// [RULE_18] Behaviour code 01 enters standby at bus off, no recovery flag.
// [RULE_19] Code 11 with standby request during bus off: no recovery flag.
// [RULE_20] Flags are sticky until software clears them.
module ccee_channel_events
  import ccee_pkg::*;
(
  input wire logic pclk,                 // APB clock, 125 MHz
  input wire logic presetn,              // Asynchronous reset, active low
  input wire logic psel,                 // APB select
  input wire logic penable,              // APB access phase
  input wire logic pwrite,               // APB write
  input wire logic [11:0] paddr,         // APB byte address
  input wire logic [31:0] pwdata,        // APB write data
  output logic [31:0] prdata,            // APB read data
  output logic pready,                   // APB ready, always high
  output logic pslverr,                  // Unmapped address
  input wire ccee_evt_t evt,             // Protocol engine strobes
  input wire logic can_rx,               // Sampled bus level, 0 dominant
  input wire logic can_tx_drive,         // Level the node drives
  input wire logic [7:0] rx_fifo_level,  // Receive FIFO messages stored
  input wire logic [7:0] txrx_fifo_level,// Tx/rx FIFO messages stored
  output logic channel_irq,              // Channel error interrupt
  output logic wakeup_irq,               // Wakeup interrupt
  output logic rx_fifo_irq,              // Receive FIFO threshold reached
  output logic txrx_fifo_irq,            // Tx/rx FIFO threshold reached
  output logic busoff,                   // Node is bus off
  output logic [1:0] channel_mode        // Effective mode, ccee_mode_t code
);

  // ========================================================================
  // APB decode
  logic wr_en;
  logic rd_hit;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      `CCEE_CTRL_OFF, `CCEE_ERFL_OFF, `CCEE_FIFO_OFF, `CCEE_STAT_OFF: ;
      default: rd_hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !rd_hit;

  // ========================================================================
  // Registers and state
  logic [31:0] channel_control_reg, channel_control_next;
  logic [`CCEE_ERFL_NFLAGS-1:0] channel_error_flag_reg;
  logic [`CCEE_ERFL_NFLAGS-1:0] channel_error_flag_next;
  logic [15:0] fifo_cfg_reg, fifo_cfg_next;
  logic [8:0] tec_reg, tec_next;
  logic [7:0] rec_reg, rec_next;
  ccee_state_t state_reg, state_next;
  logic [5:0] rrun_reg, rrun_next;
  logic [7:0] rseq_reg, rseq_next;
  logic [5:0] drun_reg, drun_next;
  logic rx_prev_reg;
  logic [31:0] prdata_next;

  logic passive_irq_en, busoff_start_irq_en, busoff_recover_irq_en;
  logic overload_irq_en, buslock_irq_en, arb_lost_irq_en;
  logic force_busoff_recover;
  logic [1:0] channel_mode_change, busoff_behaviour;
  assign passive_irq_en = channel_control_reg[`CCEE_CTRL_PASSIVE_IRQ_EN];
  assign busoff_start_irq_en = channel_control_reg[`CCEE_CTRL_BUSOFF_START_IRQ_EN];
  assign busoff_recover_irq_en = channel_control_reg[`CCEE_CTRL_BUSOFF_RECOVER_IRQ_EN];
  assign overload_irq_en = channel_control_reg[`CCEE_CTRL_OLIE];
  assign buslock_irq_en = channel_control_reg[`CCEE_CTRL_BUSLOCK_IRQ_EN];
  assign arb_lost_irq_en = channel_control_reg[`CCEE_CTRL_ARB_LOST_IRQ_EN];
  assign channel_mode_change =
    channel_control_reg[`CCEE_CTRL_MODE_LO +: 2];
  assign busoff_behaviour = channel_control_reg[`CCEE_CTRL_BOM_LO +: 2];
  // Recovery bit is a write pulse; it never stays stored
  assign force_busoff_recover = wr_en && paddr == `CCEE_CTRL_OFF &&
    pwdata[`CCEE_CTRL_FORCE_BUSOFF_RECOVER];

  // ========================================================================
  // Error detection
  logic bit0_err, bit1_err, fell, to_busoff, recovered;
  logic [6:0] det;
  logic [8:0] rec_ext;
  assign bit0_err = evt.bit_tick && !can_tx_drive && can_rx;  // [RULE_12]
  assign bit1_err = evt.bit_tick && can_tx_drive && !can_rx;  // [RULE_12]
  assign det = {evt.stuff_err, evt.form_err, evt.ack_err, evt.crc_err,
                bit1_err, bit0_err, evt.ack_delim_err};
  assign fell = rx_prev_reg && !can_rx;
  assign rec_ext = {1'b0, rec_reg};

  // ========================================================================
  // Counters, bus-off and recovery
  always_comb begin
    tec_next = tec_reg;
    rec_next = rec_reg;
    state_next = state_reg;
    rrun_next = rrun_reg;
    rseq_next = rseq_reg;
    drun_next = drun_reg;
    to_busoff = 1'b0;
    recovered = 1'b0;
    case (state_reg)
      CCEE_ACTIVE: begin
        if (evt.err_inc_tx || bit0_err || bit1_err) begin
          tec_next = tec_reg + 9'h008;
        end else if (evt.ok_tx && tec_reg != 9'h000) begin
          tec_next = tec_reg - 9'h001;
        end
        if (evt.err_inc_rx && rec_reg != 8'hFF) begin
          rec_next = rec_reg + 8'h01;
        end else if (evt.ok_rx && rec_reg != 8'h00) begin
          rec_next = rec_reg - 8'h01;
        end
        if (tec_next > `CCEE_BUSOFF_LIMIT) begin  // [RULE_03]
          to_busoff = 1'b1;
          rrun_next = 6'h00;
          rseq_next = 8'h00;
          state_next = (busoff_behaviour == 2'h1) ?  // [RULE_18]
            CCEE_STANDBY : CCEE_BUSOFF;
        end
      end
      CCEE_BUSOFF: begin
        if (channel_mode_change == CCEE_MODE_RESET ||  // [RULE_16]
            force_busoff_recover) begin               // [RULE_17]
          state_next = CCEE_ACTIVE;
          tec_next = 9'h000;
          rec_next = 8'h00;
        end else if (busoff_behaviour == 2'h3 &&
                     channel_mode_change == CCEE_MODE_STANDBY) begin
          state_next = CCEE_STANDBY;  // [RULE_19]
        end else if (evt.bit_tick) begin
          if (!can_rx) begin
            rrun_next = 6'h00;
          end else if (rrun_reg == `CCEE_RECESSIVE_RUN - 6'h01) begin
            rrun_next = 6'h00;
            rseq_next = rseq_reg + 8'h01;
            if (rseq_reg == `CCEE_RECOVERY_SEQS - 8'h01) begin
              recovered = 1'b1;  // [RULE_04]
              state_next = CCEE_ACTIVE;
              tec_next = 9'h000;
              rec_next = 8'h00;
            end
          end else begin
            rrun_next = rrun_reg + 6'h01;
          end
        end
      end
      CCEE_STANDBY: begin
        if (channel_mode_change == CCEE_MODE_RESET ||
            force_busoff_recover) begin
          state_next = CCEE_ACTIVE;
          tec_next = 9'h000;
          rec_next = 8'h00;
        end
      end
      default: state_next = CCEE_ACTIVE;
    endcase
    if (evt.bit_tick) begin
      if (can_rx || channel_mode_change != CCEE_MODE_COMM) begin
        drun_next = 6'h00;
      end else if (drun_reg != `CCEE_LOCK_RUN) begin
        drun_next = drun_reg + 6'h01;
      end
    end
  end

  // ========================================================================
  // Sticky flags; a set in the same cycle beats a software clear
  logic [`CCEE_ERFL_NFLAGS-1:0] set_vec;
  always_comb begin
    set_vec = '0;
    set_vec[`CCEE_ERFL_BEF] = |det;  // [RULE_11]
    set_vec[`CCEE_ERFL_EWF] = tec_reg > `CCEE_WARN_LIMIT ||
      rec_ext > `CCEE_WARN_LIMIT;  // [RULE_01]
    set_vec[`CCEE_ERFL_EPF] = tec_reg > `CCEE_PASSIVE_LIMIT ||
      rec_ext > `CCEE_PASSIVE_LIMIT;  // [RULE_02]
    set_vec[`CCEE_ERFL_BUSOFF_START_FLAG] = to_busoff;  // [RULE_03]
    set_vec[`CCEE_ERFL_BUSOFF_RECOVER_FLAG] = recovered;  // [RULE_04]
    set_vec[`CCEE_ERFL_OVERLOAD_FLAG] = evt.overload;  // [RULE_05]
    set_vec[`CCEE_ERFL_BLF] = evt.bit_tick && !can_rx &&
      drun_reg == `CCEE_LOCK_RUN - 6'h01 &&
      channel_mode_change == CCEE_MODE_COMM;  // [RULE_06]
    set_vec[`CCEE_ERFL_ALF] = evt.arb_lost;  // [RULE_07]
    set_vec[`CCEE_ERFL_WUF] = fell;  // [RULE_08]
    set_vec[`CCEE_ERFL_DET_LO +: 7] = det;  // [RULE_11]
    channel_error_flag_next = channel_error_flag_reg;
    if (wr_en && paddr == `CCEE_ERFL_OFF) begin
      // Writing 0 clears a flag, writing 1 leaves it  [RULE_10]
      channel_error_flag_next = channel_error_flag_reg &
        pwdata[`CCEE_ERFL_NFLAGS-1:0];
    end
    channel_error_flag_next = channel_error_flag_next | set_vec;  // [RULE_20]
  end

  // ========================================================================
  // Register writes
  always_comb begin
    channel_control_next = channel_control_reg;
    fifo_cfg_next = fifo_cfg_reg;
    if (wr_en && paddr == `CCEE_CTRL_OFF) begin
      channel_control_next = pwdata & 32'h0033_01FF;
    end
    if (wr_en && paddr == `CCEE_FIFO_OFF) begin
      fifo_cfg_next = pwdata[15:0] & 16'h7777;
    end
    // Automatic standby entry shows in the mode field
    if (state_reg == CCEE_ACTIVE && state_next == CCEE_STANDBY) begin
      channel_control_next[`CCEE_CTRL_MODE_LO +: 2] = 2'h2;  // [RULE_18]
    end
  end

  // ========================================================================
  // FIFO thresholds: level compared against depth*(code+1)/8
  function automatic logic fifo_hit(input logic [2:0] thr,
                                    input logic [2:0] dcode,
                                    input logic [7:0] level);
    logic [7:0] depth;
    logic [10:0] lhs;
    logic [10:0] rhs;
    depth = 8'h00;
    lhs = 11'h000;
    rhs = 11'h000;
    case (dcode)
      3'h0: depth = 8'h00;
      3'h1: depth = 8'h04;
      3'h2: depth = 8'h08;
      3'h3: depth = 8'h10;
      3'h4: depth = 8'h20;
      3'h5: depth = 8'h30;
      3'h6: depth = 8'h40;
      default: depth = 8'h80;
    endcase
    lhs = {level, 3'h0};
    rhs = {3'h0, depth} * ({8'h00, thr} + 11'h001);
    // Odd eighths at depth 4 fall between messages; software avoids them
    fifo_hit = depth != 8'h00 && lhs >= rhs;  // [RULE_13] [RULE_15]
  endfunction

  // ========================================================================
  // Read mux
  always_comb begin
    prdata_next = 32'h0000_0000;
    case (paddr)
      `CCEE_CTRL_OFF: prdata_next = channel_control_reg;
      `CCEE_ERFL_OFF: prdata_next = {16'h0000, channel_error_flag_reg};
      `CCEE_FIFO_OFF: prdata_next = {txrx_fifo_level, rx_fifo_level,
                                     fifo_cfg_reg};
      `CCEE_STAT_OFF: prdata_next = {6'h00, busoff, 6'h00,
                                     channel_mode, tec_reg, rec_reg};
      default: prdata_next = 32'h0000_0000;
    endcase
  end
  assign prdata = prdata_next;

  // ========================================================================
  // Flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_control_reg <= `CCEE_CTRL_RESET;
      channel_error_flag_reg <= '0;
      fifo_cfg_reg <= 16'h0000;
      tec_reg <= 9'h000;
      rec_reg <= 8'h00;
      state_reg <= CCEE_ACTIVE;
      rrun_reg <= 6'h00;
      rseq_reg <= 8'h00;
      drun_reg <= 6'h00;
      rx_prev_reg <= 1'b1;
    end else begin
      channel_control_reg <= channel_control_next;
      channel_error_flag_reg <= channel_error_flag_next;
      fifo_cfg_reg <= fifo_cfg_next;
      tec_reg <= tec_next;
      rec_reg <= rec_next;
      state_reg <= state_next;
      rrun_reg <= rrun_next;
      rseq_reg <= rseq_next;
      drun_reg <= drun_next;
      rx_prev_reg <= can_rx;
    end
  end

  // ========================================================================
  // Interrupt outputs
  logic [7:0] en_vec;
  assign en_vec = channel_control_reg[7:0];
  assign channel_irq = |(en_vec & channel_error_flag_reg[7:0]);  // [RULE_09]
  assign wakeup_irq = channel_control_reg[`CCEE_CTRL_WUIE] &&
    channel_error_flag_reg[`CCEE_ERFL_WUF];  // [RULE_08]
  assign rx_fifo_irq = fifo_hit(fifo_cfg_reg[2:0], fifo_cfg_reg[6:4],
                                rx_fifo_level);
  assign txrx_fifo_irq = fifo_hit(fifo_cfg_reg[10:8], fifo_cfg_reg[14:12],
                                  txrx_fifo_level);
  assign busoff = state_reg == CCEE_BUSOFF;
  assign channel_mode = (state_reg == CCEE_STANDBY) ? 2'h2 :
    channel_mode_change;

  // ========================================================================
  // Assertions
  property p_warn;
    @(posedge pclk) disable iff (!presetn)
    (tec_reg > 9'd95 || rec_reg > 8'd95) |=> channel_error_flag_reg[1];
  endproperty
  a_warn: assert property (p_warn) // [RULE_01]
    else $error("warning flag missed");
  property p_passive;
    @(posedge pclk) disable iff (!presetn)
    (tec_reg > 9'd127 || rec_reg > 8'd127) |=> channel_error_flag_reg[2];
  endproperty
  a_passive: assert property (p_passive) // [RULE_02]
    else $error("passive missed");
  property p_boff;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCEE_ACTIVE && state_next != CCEE_ACTIVE)
      |=> channel_error_flag_reg[3];
  endproperty
  a_boff: assert property (p_boff) // [RULE_03]
    else $error("bus-off flag missed");
  property p_busoff_recover_flag_src;
    @(posedge pclk) disable iff (!presetn)
    $rose(channel_error_flag_reg[4]) |-> $past(state_reg == CCEE_BUSOFF);
  endproperty
  a_busoff_recover_flag_src: assert property (p_busoff_recover_flag_src) // [RULE_16]
    else $error("stray recovery");
  property p_force;
    @(posedge pclk) disable iff (!presetn)
    (busoff && force_busoff_recover && !recovered)
      |=> !busoff && ($stable(channel_error_flag_reg[4]) ||
                      !channel_error_flag_reg[4]);
  endproperty
  a_force: assert property (p_force) else $error("forced recovery"); // [RULE_17]
  property p_arb;
    @(posedge pclk) disable iff (!presetn)
    evt.arb_lost |=> channel_error_flag_reg[7];
  endproperty
  a_arb: assert property (p_arb) else $error("arb lost missed"); // [RULE_07]
  property p_wake;
    @(posedge pclk) disable iff (!presetn)
    (fell && channel_control_reg[8]) |=> wakeup_irq;
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup missed"); // [RULE_08]
  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
    (channel_error_flag_reg[5] && !(wr_en && paddr == `CCEE_ERFL_OFF))
      |=> channel_error_flag_reg[5];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped"); // [RULE_20]
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    channel_irq |-> |(channel_control_reg[7:0] & channel_error_flag_reg[7:0]);
  endproperty
  a_irq: assert property (p_irq) else $error("ungated interrupt"); // [RULE_09]
  c_busoff: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(busoff));
  c_recover: cover property (@(posedge pclk) disable iff (!presetn)
    recovered);
  c_lock: cover property (@(posedge pclk) disable iff (!presetn)
    set_vec[6]);

endmodule // ccee_channel_events
`default_nettype wire

/* logic/ccee_regs.svh */
// Register offsets, field positions and reset values of the CAN channel
// error/event block. Assumes a 32-bit APB with word-aligned registers.
`ifndef CCEE_REGS_SVH
`define CCEE_REGS_SVH

// ==========================================================================
// Offsets
`define CCEE_CTRL_OFF 12'h000
`define CCEE_ERFL_OFF 12'h004
`define CCEE_FIFO_OFF 12'h008
`define CCEE_STAT_OFF 12'h00C

// ==========================================================================
// Control register fields
`define CCEE_CTRL_BEIE 0
`define CCEE_CTRL_EWIE 1
`define CCEE_CTRL_PASSIVE_IRQ_EN 2
`define CCEE_CTRL_BUSOFF_START_IRQ_EN 3
`define CCEE_CTRL_BUSOFF_RECOVER_IRQ_EN 4
`define CCEE_CTRL_OLIE 5
`define CCEE_CTRL_BUSLOCK_IRQ_EN 6
`define CCEE_CTRL_ARB_LOST_IRQ_EN 7
`define CCEE_CTRL_WUIE 8
`define CCEE_CTRL_MODE_LO 16
`define CCEE_CTRL_BOM_LO 20
`define CCEE_CTRL_FORCE_BUSOFF_RECOVER 24
`define CCEE_CTRL_RESET 32'h0000_0000

// ==========================================================================
// Error flag register fields
`define CCEE_ERFL_BEF 0
`define CCEE_ERFL_EWF 1
`define CCEE_ERFL_EPF 2
`define CCEE_ERFL_BUSOFF_START_FLAG 3
`define CCEE_ERFL_BUSOFF_RECOVER_FLAG 4
`define CCEE_ERFL_OVERLOAD_FLAG 5
`define CCEE_ERFL_BLF 6
`define CCEE_ERFL_ALF 7
`define CCEE_ERFL_WUF 8
`define CCEE_ERFL_DET_LO 9
`define CCEE_ERFL_NFLAGS 16

// ==========================================================================
// FIFO config fields: rx thr [2:0], rx depth [6:4], trx thr [10:8], trx
// depth [14:12], rx level [23:16], trx level [31:24] (level read-only)
`define CCEE_FIFO_RXLVL_LO 16
`define CCEE_FIFO_TXLVL_LO 24

// ==========================================================================
// Counters and thresholds
`define CCEE_WARN_LIMIT 9'd95
`define CCEE_PASSIVE_LIMIT 9'd127
`define CCEE_BUSOFF_LIMIT 9'd255
`define CCEE_RECESSIVE_RUN 6'd11
`define CCEE_RECOVERY_SEQS 8'd128
`define CCEE_LOCK_RUN 6'd32

`endif

/* logic/ccee_pkg.sv */
// Types of the CAN channel error/event block.
// Assumes ccee_regs.svh holds the numeric constants.
package ccee_pkg;

  // ========================================================================
  // Channel mode change codes
  typedef enum logic [1:0] {
    CCEE_MODE_COMM = 2'h0,
    CCEE_MODE_RESET = 2'h1,
    CCEE_MODE_STANDBY = 2'h2,
    CCEE_MODE_KEEP = 2'h3
  } ccee_mode_t;

  // ========================================================================
  // Protocol engine event strobes, one cycle each
  typedef struct packed {
    logic bit_tick;    // One pulse per sampled bit
    logic overload;
    logic arb_lost;
    logic ack_delim_err;
    logic crc_err;
    logic ack_err;
    logic form_err;
    logic stuff_err;
    logic err_inc_tx;  // Transmit error counter +8
    logic err_inc_rx;  // Receive error counter +1
    logic ok_tx;       // Successful transmit, counter -1
    logic ok_rx;       // Successful receive, counter -1
  } ccee_evt_t;

  typedef enum {
    CCEE_ACTIVE,
    CCEE_BUSOFF,
    CCEE_STANDBY
  } ccee_state_t;

endpackage

/* tb/ccee_bus_model.sv */
// Bus-side partner: engine strobes, bus level and FIFO fill levels.
// Assumes one bench process calls its tasks, one at a time.
`timescale 1ns/1ps
`default_nettype none
module ccee_bus_model
  import ccee_pkg::*;
(
  input wire logic pclk, // Channel clock
  output var ccee_evt_t evt, // Event strobes
  output var logic can_rx, // Bus level, 1 recessive
  output var logic can_tx_drive, // Level our node drives
  output var logic [7:0] rx_lvl, // Receive FIFO fill
  output var logic [7:0] trx_lvl // Tx/rx FIFO fill
);
  initial begin
    evt = '0;
    can_rx = 1'b1;
    can_tx_drive = 1'b1;
    rx_lvl = '0;
    trx_lvl = '0;
  end
  // ==========================================================
  // Stimulus tasks
  task automatic pulse(input int b);
    @(posedge pclk);
    evt <= ccee_evt_t'(12'h001 << b);
    @(posedge pclk);
    evt <= '0;
  endtask
  // The pull-up takes the bus back to recessive after every burst
  task automatic bits(input int n, input logic lvl, input logic drv);
    repeat (n) begin
      @(posedge pclk);
      evt <= ccee_evt_t'(12'h800);
      can_rx <= lvl;
      can_tx_drive <= drv;
    end
    @(posedge pclk);
    evt <= '0;
    can_rx <= 1'b1;
    can_tx_drive <= 1'b1;
  endtask
  task automatic set_lvl(input logic [7:0] r, input logic [7:0] t);
    @(posedge pclk);
    rx_lvl <= r;
    trx_lvl <= t;
  endtask
endmodule // ccee_bus_model
`default_nettype wire

/* tb/ccee_channel_events_tb.sv */
// Self-checking bench of the channel event block over APB.
// Assumes ccee_bus_model stands in for the protocol engine and bus.
`timescale 1ns/1ps
`default_nettype none
`include "ccee_regs.svh"
module ccee_channel_events_tb
  import ccee_pkg::*;
;
  localparam logic [31:0] EN = 32'h0000_01FF;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, stuff_err_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  ccee_evt_t evt;
  logic can_rx, can_tx_drive, channel_irq, wakeup_irq;
  logic rx_fifo_irq, txrx_fifo_irq, busoff;
  logic [7:0] rx_lvl, trx_lvl;
  logic [1:0] channel_mode;
  int failures = 0;
  int n_tests = 0;
  int eb[7] = '{10, 9, 8, 7, 6, 5, 4};
  logic [31:0] ef[7] = '{32'h20, 32'h80, 32'h201, 32'h1001, 32'h2001,
    32'h4001, 32'h8001};
  logic [31:0] pre[4] = '{EN, EN, EN | 32'h0010_0000, EN | 32'h0030_0000};
  logic [31:0] post[4] = '{EN | 32'h0100_0000, EN | 32'h0001_0000,
    EN | 32'h0010_0000, EN | 32'h0032_0000};

  always #4 pclk = ~pclk;

  ccee_channel_events i_ccee_channel_events (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .can_rx(can_rx),
    .can_tx_drive(can_tx_drive), .rx_fifo_level(rx_lvl),
    .txrx_fifo_level(trx_lvl), .channel_irq(channel_irq),
    .wakeup_irq(wakeup_irq), .rx_fifo_irq(rx_fifo_irq),
    .txrx_fifo_irq(txrx_fifo_irq), .busoff(busoff),
    .channel_mode(channel_mode));
  ccee_bus_model i_ccee_bus_model (.pclk(pclk), .evt(evt), .can_rx(can_rx),
    .can_tx_drive(can_tx_drive), .rx_lvl(rx_lvl), .trx_lvl(trx_lvl));

  // ==========================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Holds the request until pready is seen high, then releases it
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      failures++;
      end_sim();
    end
    rdat = prdata;
    stuff_err_flag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rdat & m, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic clr();
    wr(`CCEE_ERFL_OFF, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tick(4);
    presetn <= 1'b1;
    rd(`CCEE_CTRL_OFF, '1, 32'h0, "ctrl_rst");
    rd(`CCEE_ERFL_OFF, '1, 32'h0, "flag_rst");
    rd(`CCEE_STAT_OFF, '1, 32'h0, "stat_rst");
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped_err", 32'(stuff_err_flag), 32'h1);
    $display("test reset done");
    i_ccee_bus_model.pulse(10);
    rd(`CCEE_ERFL_OFF, '1, 32'h20, "ovl_flag");
    check("irq_masked", 32'(channel_irq), 32'h0);
    wr(`CCEE_CTRL_OFF, EN);
    tick(2);
    check("irq_enabled", 32'(channel_irq), 32'h1);
    tick(20);
    rd(`CCEE_ERFL_OFF, '1, 32'h20, "ovl_sticky");
    check("irq_held", 32'(channel_irq), 32'h1);
    clr();
    tick(2);
    check("irq_cleared", 32'(channel_irq), 32'h0);
    for (int i = 0; i < 7; i++) begin
      i_ccee_bus_model.pulse(eb[i]);
      tick(1);
      check("evt_irq", 32'(channel_irq), 32'h1);
      rd(`CCEE_ERFL_OFF, '1, ef[i], "evt_flag");
      clr();
    end
    i_ccee_bus_model.bits(1, 1'b1, 1'b0);
    rd(`CCEE_ERFL_OFF, '1, 32'h401, "bit0_err");
    clr();
    i_ccee_bus_model.bits(1, 1'b0, 1'b1);
    rd(`CCEE_ERFL_OFF, '1, 32'h901, "bit1_err_wake");
    check("wake_irq", 32'(wakeup_irq), 32'h1);
    clr();
    tick(2);
    check("wake_cleared", 32'(wakeup_irq), 32'h0);
    $display("test events done");
    // Transmit count is 16 here after the two bit errors
    repeat (9) i_ccee_bus_model.pulse(3);
    rd(`CCEE_ERFL_OFF, 32'h1F, 32'h0, "tec88");
    i_ccee_bus_model.pulse(3);
    rd(`CCEE_ERFL_OFF, 32'h1F, 32'h2, "tec96");
    repeat (3) i_ccee_bus_model.pulse(3);
    rd(`CCEE_ERFL_OFF, 32'h1F, 32'h2, "tec120");
    i_ccee_bus_model.pulse(3);
    rd(`CCEE_ERFL_OFF, 32'h1F, 32'h6, "tec128");
    check("not_off", 32'(busoff), 32'h0);
    repeat (16) i_ccee_bus_model.pulse(3);
    rd(`CCEE_ERFL_OFF, 32'h1F, 32'hE, "tec256");
    check("off", 32'(busoff), 32'h1);
    clr();
    i_ccee_bus_model.bits(1407, 1'b1, 1'b1);
    check("off_127_runs", 32'(busoff), 32'h1);
    i_ccee_bus_model.bits(1, 1'b1, 1'b1);
    tick(2);
    check("recovered", 32'(busoff), 32'h0);
    rd(`CCEE_ERFL_OFF, 32'h10, 32'h10, "recov_flag");
    $display("test counters done");
    for (int i = 0; i < 4; i++) begin
      wr(`CCEE_CTRL_OFF, pre[i]);
      clr();
      repeat (33) i_ccee_bus_model.pulse(3);
      wr(`CCEE_CTRL_OFF, post[i]);
      tick(2);
      if (i >= 2) check("standby", 32'(channel_mode), 32'h2);
      if (i == 0) check("forced", 32'(busoff), 32'h0);
      i_ccee_bus_model.bits(1408, 1'b1, 1'b1);
      rd(`CCEE_ERFL_OFF, 32'h10, 32'h0, "no_recov");
      // Mode reset leaves any standby, so the next pass starts active
      wr(`CCEE_CTRL_OFF, EN | 32'h0001_0000);
    end
    $display("test suppress done");
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    wr(`CCEE_CTRL_OFF, EN);
    i_ccee_bus_model.bits(31, 1'b0, 1'b0);
    rd(`CCEE_ERFL_OFF, 32'h40, 32'h0, "lock31");
    i_ccee_bus_model.bits(32, 1'b0, 1'b0);
    rd(`CCEE_ERFL_OFF, 32'h40, 32'h40, "lock32");
    repeat (96) i_ccee_bus_model.pulse(2);
    rd(`CCEE_ERFL_OFF, 32'h2, 32'h2, "rec96");
    i_ccee_bus_model.pulse(0);
    clr();
    rd(`CCEE_ERFL_OFF, 32'h2, 32'h0, "rec95");
    repeat (33) i_ccee_bus_model.pulse(2);
    rd(`CCEE_ERFL_OFF, 32'h4, 32'h4, "rec128");
    i_ccee_bus_model.pulse(3);
    i_ccee_bus_model.pulse(1);
    rd(`CCEE_STAT_OFF, 32'h1FFFF, 32'h780, "tec7_rec128");
    $display("test buslock done");
    // Depth code 2 only: odd eighths stay off depth code 1
    for (int t = 0; t < 8; t++) begin
      wr(`CCEE_FIFO_OFF, 32'(t) | 32'h20 | (32'(t) << 8) | 32'h2000);
      i_ccee_bus_model.set_lvl(8'(t), 8'(t));
      tick(2);
      check("rx_below", 32'(rx_fifo_irq), 32'h0);
      check("trx_below", 32'(txrx_fifo_irq), 32'h0);
      i_ccee_bus_model.set_lvl(8'(t + 1), 8'(t + 1));
      tick(2);
      check("rx_at", 32'(rx_fifo_irq), 32'h1);
      check("trx_at", 32'(txrx_fifo_irq), 32'h1);
    end
    $display("test fifo done");
    end_sim();
  end
endmodule // ccee_channel_events_tb
`default_nettype wire
